//--- ppd_consts.svh
// constants for the parallel port fifo dma and run-length block
// assumes inclusion by bare name from the package and every module but the host model
`ifndef PPD_CONSTS_SVH
`define PPD_CONSTS_SVH
// apb byte addresses
`define PPD_OFS_DATA      12'h000
`define PPD_OFS_FIFO      12'h400
`define PPD_OFS_CFGB      12'h404
`define PPD_OFS_ECR       12'h408
`define PPD_OFS_CTRL      12'h40C
// extended control, config b and control register fields
`define PPD_ECR_RST       8'h15
`define PPD_ECR_EMPTY     0
`define PPD_ECR_FULL      1
`define PPD_ECR_SI        2
`define PPD_ECR_DMA       3
`define PPD_ECR_MODE_LO   5
`define PPD_ECR_MODE_HI   7
`define PPD_CFGB_RLE      7
`define PPD_CTRL_DIR      0
// mode field codes
`define PPD_MODE_SPP      3'h0
`define PPD_MODE_PS2      3'h1
`define PPD_MODE_PPF      3'h2
`define PPD_MODE_ECP      3'h3
`define PPD_MODE_TST      3'h6
// fifo shape
`define PPD_FIFO_DEPTH    16
`define PPD_FIFO_AW       4
`define PPD_FIFO_W        9
// timing
`define PPD_BURST_MAX     6'h20
`define PPD_CLK_NS        5
`define PPD_INTR_NS       200
`define PPD_INTR_CYC      ((`PPD_INTR_NS + `PPD_CLK_NS - 1) / `PPD_CLK_NS)
`endif

//--- ppd_pkg.sv
// types shared by the fifo dma block
// assumes ppd_consts.svh is on the include path
`include "ppd_consts.svh"
package ppd_pkg;
    typedef enum logic [2:0] {
        PPD_MODE_SPP = `PPD_MODE_SPP,
        PPD_MODE_PS2 = `PPD_MODE_PS2,
        PPD_MODE_PPF = `PPD_MODE_PPF,
        PPD_MODE_ECP = `PPD_MODE_ECP,
        PPD_MODE_TST = `PPD_MODE_TST
    } ppd_mode_type;
    typedef enum logic [1:0] {
        PPD_APB_IDLE = 2'h1,
        PPD_APB_WAIT = 2'h2
    } ppd_apb_state_type;
endpackage

//--- ppd_fifo.sv
// 16 entry fifo, 8 data bits plus one tag bit
// assumes one push and one pop per cycle at most, all on pclk
`include "ppd_consts.svh"
module ppd_fifo
    import ppd_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      push,
    input  wire logic [`PPD_FIFO_W-1:0]    push_data,
    input  wire logic                      pop,
    output logic      [`PPD_FIFO_W-1:0]    head,
    output logic                           full,
    output logic                           empty
);
    logic [`PPD_FIFO_W-1:0] mem_ff [`PPD_FIFO_DEPTH];
    logic [`PPD_FIFO_AW:0]  wr_ptr_ff;
    logic [`PPD_FIFO_AW:0]  rd_ptr_ff;
    wire                    do_push = push && !full;
    wire                    do_pop  = pop && !empty;

    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign full  = (wr_ptr_ff[`PPD_FIFO_AW] != rd_ptr_ff[`PPD_FIFO_AW]) &&
                   (wr_ptr_ff[`PPD_FIFO_AW-1:0] == rd_ptr_ff[`PPD_FIFO_AW-1:0]);
    assign head  = mem_ff[rd_ptr_ff[`PPD_FIFO_AW-1:0]];

    // push into a full fifo is lost
    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem_ff[wr_ptr_ff[`PPD_FIFO_AW-1:0]] <= push_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (do_push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (do_pop)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
endmodule // ppd_fifo

//--- ppd_rle.sv
// run-length expander on the host read side of the fifo
// assumes rd_done only while avail is high
`include "ppd_consts.svh"
module ppd_rle
    import ppd_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      en,
    input  wire logic [`PPD_FIFO_W-1:0]    head,
    input  wire logic                      empty,
    input  wire logic                      hold,
    input  wire logic                      rd_done,
    output logic                           pop,
    output logic                           avail
);
    logic       active_ff;
    logic [6:0] count_ff;
    // length byte: data bit 7 and tag both low
    wire is_len  = en && !empty && !active_ff && !head[7] && !head[8]; // R14
    // length byte swallowed between host reads
    wire do_load = is_len && !hold;
    wire last    = !active_ff || (count_ff == 7'h00);

    assign avail = !empty && !is_len;
    assign pop   = do_load || (rd_done && last); // R15

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_ff <= 1'b0;
            count_ff  <= 7'h00;
        end else if (!en) begin
            active_ff <= 1'b0;
            count_ff  <= 7'h00;
        end else if (do_load) begin
            active_ff <= 1'b1;
            count_ff  <= head[6:0]; // R14
        end else if (rd_done && active_ff) begin
            active_ff <= !last; // R20
            count_ff  <= last ? 7'h00 : count_ff - 7'h01; // R15 R20
        end
    end
endmodule // ppd_rle

//--- ppd_dma.sv
// fifo data port with dma request control and run-length expansion
// assumes raw host dma pins, peripheral engine on pclk
//
// Summary of operation
// R1: terminal count sets service bit, stops requests
// R2: dma only to fifo port, fifo modes
// R3: request when enabled, service low, fifo ready
// R4: acknowledged strobes move data fifo and host
// R5: request drops on full, empty, service high; in test mode the request stays up on full and empty
// R6: request drops after over 32 consecutive cycles
// R7: full or empty withdrawal restarts automatically
// R8: acknowledge high clears consecutive-cycle counter
// R9: host clears service bit to resume
// R10: compression unsupported, config bit 7 reads zero
// R11: length byte written at 000, tag zero
// R12: host follows length byte with data byte
// R13: expansion only in reverse direction reads
// R14: length byte loads bits 0-6 into counter
// R15: next byte returned count plus one times
// R16: terminal count gives 200 ns interrupt pulse
// R17: 400 and dma writes tag high, 000 low
// R18: mode codes 010, 011 and 110
// R19: outside fifo modes request low, counter clear
// R20: finished run clears counter, rechecks next byte
//
// Implementation choices: the placing of the registers and register access over APB.
`include "ppd_consts.svh"
module ppd_dma
    import ppd_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    // apb register bus
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // host dma pins
    input  wire logic          peripheral_dma_ack_n,
    input  wire logic          dma_wr_n,
    input  wire logic          dma_rd_n,
    input  wire logic          dma_tc,
    input  wire logic [7:0]    dma_wdata,
    output logic               dma_req,
    output logic      [7:0]    dma_rdata,
    output logic               service_intr,
    // peripheral handshake engine
    input  wire logic          per_push,
    input  wire logic [8:0]    per_push_data,
    input  wire logic          per_pop,
    output logic      [8:0]    per_rdata,
    output logic               fifo_full,
    output logic               fifo_empty,
    output logic               port_direction,
    output logic      [2:0]    port_mode
);
    // ****
    // decoding helpers
    // ****
    function automatic logic is_fifo_mode(input logic [2:0] m);
        is_fifo_mode = (m == PPD_MODE_PPF) || (m == PPD_MODE_ECP) ||
                       (m == PPD_MODE_TST); // R18
    endfunction

    function automatic logic is_open_mode(input logic [2:0] m);
        is_open_mode = (m == PPD_MODE_SPP) || (m == PPD_MODE_PS2);
    endfunction

    // ****
    // pin synchronisers
    // ****
    logic [3:0]  pin_s1_ff;
    logic [3:0]  pin_s2_ff;
    logic [3:0]  pin_s3_ff;
    logic [7:0]  wd_s1_ff;
    logic [7:0]  wd_s2_ff;

    // ack_n, wr_n, rd_n, tc; stage three only feeds edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_ff <= 4'h7;
            pin_s2_ff <= 4'h7;
            pin_s3_ff <= 4'h7;
            wd_s1_ff  <= 8'h00;
            wd_s2_ff  <= 8'h00;
        end else begin
            pin_s1_ff <= {peripheral_dma_ack_n, dma_wr_n, dma_rd_n, dma_tc};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            wd_s1_ff  <= dma_wdata;
            wd_s2_ff  <= wd_s1_ff;
        end
    end

    wire ack_low  = !pin_s2_ff[3];
    wire wr_low   = !pin_s2_ff[2];
    wire rd_low   = !pin_s2_ff[1];
    wire wr_rise  = pin_s2_ff[2] && !pin_s3_ff[2];
    wire rd_fall  = !pin_s2_ff[1] && pin_s3_ff[1];
    wire rd_rise  = pin_s2_ff[1] && !pin_s3_ff[1];
    wire tc_rise  = pin_s2_ff[0] && !pin_s3_ff[0];

    // ****
    // control registers
    // ****
    logic [2:0]  mode_ff;
    logic        err_en_ff;
    logic        dma_en_ff;
    logic        si_ff;
    logic        dir_ff;
    logic [5:0]  burst_ff;
    logic        req_ff;
    logic [7:0]  rdata_dma_ff;
    logic [5:0]  intr_cnt_ff;
    logic        intr_ff;
    logic [8:0]  per_rdata_ff;

    wire fifo_mode = is_fifo_mode(mode_ff);
    wire tst_mode  = (mode_ff == PPD_MODE_TST);
    wire ecp_mode  = (mode_ff == PPD_MODE_ECP);
    // host fills the fifo going out, and in test mode either way
    wire host_fill = !dir_ff || tst_mode;

    // ****
    // apb slave
    // ****
    ppd_apb_state_type state_ff;
    ppd_apb_state_type nxt_state;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    wire hit_data  = (paddr == `PPD_OFS_DATA);
    wire hit_fifo  = (paddr == `PPD_OFS_FIFO);
    wire hit_cfgb  = (paddr == `PPD_OFS_CFGB);
    wire hit_ecr   = (paddr == `PPD_OFS_ECR);
    wire hit_ctrl  = (paddr == `PPD_OFS_CTRL);
    wire mapped    = hit_data || hit_fifo || hit_cfgb || hit_ecr || hit_ctrl;
    wire apb_done  = psel && penable && pready_ff;
    wire apb_wr    = apb_done && pwrite && mapped;
    wire apb_rd    = apb_done && !pwrite && mapped;

    assign nxt_state = (state_ff == PPD_APB_IDLE && psel && penable && !pready_ff) ?
                       PPD_APB_WAIT : PPD_APB_IDLE;

    // ****
    // fifo and expander
    // ****
    logic [8:0]  fifo_head;
    logic        fifo_full_w;
    logic        fifo_empty_w;
    logic        rle_pop;
    logic        host_avail;

    // 000 pushes only in mode 011, tag low
    wire apb_push_data = apb_wr && hit_data && ecp_mode; // R11 R17
    wire apb_push_fifo = apb_wr && hit_fifo && fifo_mode; // R2
    wire dma_cycle     = ack_low && fifo_mode; // R2 R4
    wire dma_push      = dma_cycle && wr_rise; // R4
    wire host_read     = dir_ff || tst_mode;
    wire dma_pop_done  = dma_cycle && rd_rise && host_read; // R4 R13
    wire apb_pop_done  = apb_rd && host_read &&
                         ((hit_data && ecp_mode) || (hit_fifo && fifo_mode)); // R13
    // dma wins a same-cycle clash; apb push lost
    wire host_push     = dma_push || apb_push_fifo || apb_push_data;
    wire [8:0] host_word = dma_push ? {1'b1, wd_s2_ff} :
                           {apb_push_fifo, pwdata[7:0]}; // R17
    wire fifo_push     = host_fill ? (host_push && fifo_mode) : (per_push && fifo_mode);
    wire [8:0] fifo_wd = host_fill ? host_word : per_push_data;
    wire rd_done       = (dma_pop_done || apb_pop_done) && host_avail;
    wire per_take      = per_pop && !dir_ff && !tst_mode && !fifo_empty_w;
    wire fifo_pop      = per_take || rle_pop;
    // expand reverse reads only; test mode literal
    wire rle_en        = dir_ff && !tst_mode && fifo_mode; // R13
    wire rle_hold      = (psel && !pwrite) || (ack_low && rd_low);
    wire host_empty    = host_fill ? fifo_empty_w : !host_avail;

    ppd_fifo u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (fifo_push),
        .push_data (fifo_wd),
        .pop       (fifo_pop),
        .head      (fifo_head),
        .full      (fifo_full_w),
        .empty     (fifo_empty_w)
    );

    ppd_rle u_rle (
        .pclk      (pclk),
        .presetn   (presetn),
        .en        (rle_en),
        .head      (fifo_head),
        .empty     (fifo_empty_w),
        .hold      (rle_hold),
        .rd_done   (rd_done),
        .pop       (rle_pop),
        .avail     (host_avail)
    );

    // ****
    // register read mux
    // ****
    wire       ecr_empty = fifo_mode ? host_empty : 1'b1;
    wire       ecr_full  = fifo_mode ? fifo_full_w : 1'b0;
    wire [7:0] ecr_rd    = {mode_ff, err_en_ff, dma_en_ff, si_ff, ecr_full, ecr_empty};
    // no compressor: capability bit reads zero
    wire [7:0] cfgb_rd   = 8'h00; // R10
    wire [7:0] reg_rd    = hit_ecr  ? ecr_rd :
                           hit_cfgb ? cfgb_rd :
                           hit_ctrl ? {7'h00, dir_ff} :
                           fifo_head[7:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= PPD_APB_IDLE;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            state_ff   <= nxt_state;
            pready_ff  <= (nxt_state == PPD_APB_WAIT);
            pslverr_ff <= (nxt_state == PPD_APB_WAIT) && !mapped;
            if (nxt_state == PPD_APB_WAIT) begin
                prdata_ff <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, reg_rd};
            end
        end
    end

    // ****
    // extended control and direction
    // ****
    wire [2:0] wr_mode  = pwdata[`PPD_ECR_MODE_HI:`PPD_ECR_MODE_LO];
    // leave fifo modes only via 000 or 001
    wire       mode_ok  = is_open_mode(mode_ff) || is_open_mode(wr_mode);
    wire       ecr_wr   = apb_wr && hit_ecr;
    wire       tc_fire  = tc_rise && ack_low && fifo_mode && dma_en_ff && !si_ff; // R16

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff   <= 3'(`PPD_ECR_RST >> `PPD_ECR_MODE_LO);
            err_en_ff <= 1'b1;
            dma_en_ff <= 1'b0;
            si_ff     <= 1'b1;
            dir_ff    <= 1'b0;
        end else begin
            if (ecr_wr && mode_ok) begin
                mode_ff <= wr_mode;
            end
            if (ecr_wr) begin
                err_en_ff <= pwdata[4];
                dma_en_ff <= pwdata[`PPD_ECR_DMA];
            end
            // terminal count beats a same-cycle host clear
            if (tc_fire) begin
                si_ff <= 1'b1; // R1
            end else if (ecr_wr) begin
                si_ff <= pwdata[`PPD_ECR_SI]; // R9
            end
            if (apb_wr && hit_ctrl && mode_ff == PPD_MODE_PS2) begin
                dir_ff <= pwdata[`PPD_CTRL_DIR];
            end
        end
    end

    // ****
    // dma request and burst limit
    // ****
    wire dma_beat   = dma_cycle && (wr_rise || rd_rise);
    wire burst_over = (burst_ff > `PPD_BURST_MAX); // R6
    wire ready_dir  = (!dir_ff && !fifo_full_w) || (dir_ff && !host_empty) ||
                      tst_mode; // R3 R5 R7
    wire nxt_req    = fifo_mode && dma_en_ff && !si_ff && ready_dir &&
                      !burst_over && !tc_fire; // R3 R5 R19

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_ff <= 6'h00; // R19
            req_ff   <= 1'b0; // R19
        end else begin
            if (!ack_low || !fifo_mode) begin
                burst_ff <= 6'h00; // R8 R19
            end else if (dma_beat && !burst_over) begin
                burst_ff <= burst_ff + 6'h01; // R6
            end
            req_ff <= nxt_req; // R3 R5 R7
        end
    end

    // ****
    // dma read data and terminal count pulse
    // ****
    localparam logic [5:0] INTR_CYC = 6'(`PPD_INTR_CYC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_dma_ff <= 8'h00;
            intr_cnt_ff  <= 6'h00;
            intr_ff      <= 1'b0;
        end else begin
            // held from strobe fall to the next
            if (dma_cycle && rd_fall && host_avail) begin
                rdata_dma_ff <= fifo_head[7:0]; // R4 R15
            end
            if (tc_fire) begin
                intr_cnt_ff <= INTR_CYC; // R16
                intr_ff     <= 1'b1; // R16
            end else if (intr_cnt_ff != 6'h00) begin
                intr_cnt_ff <= intr_cnt_ff - 6'h01;
                intr_ff     <= (intr_cnt_ff != 6'h01);
            end
        end
    end

    // ****
    // peripheral side and outputs
    // ****
    logic full_ff;
    logic empty_ff;
    logic dir_out_ff;
    logic [2:0] mode_out_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_rdata_ff <= 9'h000;
            full_ff      <= 1'b0;
            empty_ff     <= 1'b1;
            dir_out_ff   <= 1'b0;
            mode_out_ff  <= 3'h0;
        end else begin
            if (per_take) begin
                per_rdata_ff <= fifo_head;
            end
            full_ff     <= fifo_full_w;
            empty_ff    <= fifo_empty_w;
            dir_out_ff  <= dir_ff;
            mode_out_ff <= mode_ff;
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign dma_req        = req_ff;
    assign dma_rdata      = rdata_dma_ff;
    assign service_intr   = intr_ff;
    assign per_rdata      = per_rdata_ff;
    assign fifo_full      = full_ff;
    assign fifo_empty     = empty_ff;
    assign port_direction = dir_out_ff;
    assign port_mode      = mode_out_ff;
endmodule // ppd_dma

//--- ppd_dma_props.sv
// assertions for ppd_dma, seen from its top-level ports only
// assumes one pclk domain and presetn asynchronous, active low
`include "ppd_consts.svh"
module ppd_dma_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        peripheral_dma_ack_n,
    input wire logic        dma_wr_n,
    input wire logic        dma_rd_n,
    input wire logic        dma_req,
    input wire logic        service_intr,
    input wire logic        fifo_full,
    input wire logic        fifo_empty,
    input wire logic        port_direction,
    input wire logic [2:0]  port_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       fmode, rise;
    logic [7:0] hi_ff;
    logic [1:0] prev_ff;
    logic [5:0] burst_ff, nxt_burst;
    // ****
    // helpers
    // ****
    assign fmode = port_mode == `PPD_MODE_PPF || port_mode == `PPD_MODE_ECP || port_mode == `PPD_MODE_TST;
    assign rise = |({dma_rd_n, dma_wr_n} & ~prev_ff);
    // saturates so long runs cannot wrap
    assign nxt_burst = peripheral_dma_ack_n ? 6'h00 : burst_ff + {5'h00, rise && burst_ff != 6'h3F};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_ff    <= 8'h00;
            prev_ff  <= 2'h3;
            burst_ff <= 6'h00;
        end else begin
            hi_ff    <= service_intr ? hi_ff + 8'h01 : 8'h00;
            prev_ff  <= {dma_rd_n, dma_wr_n};
            burst_ff <= nxt_burst;
        end
    end
    // ****
    // properties
    // ****
    sequence fwd_full_s;
        (!port_direction && fifo_full && port_mode != `PPD_MODE_TST) [*2];
    endsequence
    sequence rev_empty_s;
        (port_direction && fifo_empty && port_mode != `PPD_MODE_TST) [*2];
    endsequence
    req_mode_a: assert property (!fmode ##1 !fmode |-> !dma_req)
        else $error("request outside fifo modes");
    tc_stop_a: assert property ($rose(service_intr) |=> !dma_req [*8])
        else $error("request after terminal count");
    intr_width_a: assert property ($fell(service_intr) |-> hi_ff >= 8'd40)
        else $error("interrupt pulse too short");
    full_stop_a: assert property (fwd_full_s |-> !dma_req)
        else $error("request with fifo full");
    empty_stop_a: assert property (rev_empty_s |-> !dma_req)
        else $error("request with fifo empty");
    burst_stop_a: assert property (burst_ff > 6'd33 |-> !dma_req)
        else $error("request past burst limit");
    cfgb_rle_a: assert property (pready && !pwrite && paddr == `PPD_OFS_CFGB |-> !prdata[`PPD_CFGB_RLE])
        else $error("compression bit set");
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // ppd_dma_props
bind ppd_dma ppd_dma_props chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .peripheral_dma_ack_n(peripheral_dma_ack_n), .dma_wr_n(dma_wr_n), .dma_rd_n(dma_rd_n),
    .dma_req(dma_req), .service_intr(service_intr), .fifo_full(fifo_full), .fifo_empty(fifo_empty),
    .port_direction(port_direction), .port_mode(port_mode));

//--- ppd_host_model.sv
// host dma controller model for ppd_dma pins
// assumes pclk and task calls from the bench
module ppd_host_model (
    input  wire logic       pclk,
    input  wire logic [7:0] dma_rdata,
    output logic            peripheral_dma_ack_n,
    output logic            dma_wr_n,
    output logic            dma_rd_n,
    output logic            dma_tc,
    output logic [7:0]      dma_wdata,
    output logic            rd_v,
    output logic [7:0]      rd_q
);
    initial begin
        peripheral_dma_ack_n = 1'b1;
        dma_wr_n = 1'b1;
        dma_rd_n = 1'b1;
        dma_tc = 1'b0;
        dma_wdata = 8'h00;
        rd_v = 1'b0;
        rd_q = 8'h00;
    end
    task automatic ack(input logic lvl);
        @(posedge pclk);
        peripheral_dma_ack_n <= lvl;
    endtask
    // one strobe; len sets its pace
    task automatic strobe(input logic wr, input logic [7:0] d, input int len);
        @(posedge pclk);
        dma_wr_n <= !wr;
        dma_rd_n <= wr;
        dma_wdata <= d;
        repeat (len) @(posedge pclk);
        dma_wr_n <= 1'b1;
        dma_rd_n <= 1'b1;
        rd_q <= dma_rdata;
        rd_v <= !wr;
        @(posedge pclk);
        rd_v <= 1'b0;
        repeat (len) @(posedge pclk);
        dma_wdata <= ~dma_wdata; // hold time over, data no longer valid
    endtask
    task automatic pulse_tc();
        @(posedge pclk);
        dma_tc <= 1'b1;
        repeat (4) @(posedge pclk);
        dma_tc <= 1'b0;
    endtask
endmodule // ppd_host_model

//--- parallel_port_fifo_dma_rle_test.sv
// self-checking bench for ppd_dma with a host dma controller model
// assumes design, package and host model compiled first
`include "ppd_consts.svh"
module parallel_port_fifo_dma_rle_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite;
    logic        per_push, per_pop, pready, pslverr, dma_req, service_intr, rd_v;
    logic        ack_n, wr_n, rd_n, tc, fifo_full, fifo_empty, port_direction;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [8:0]  per_push_data, per_rdata;
    logic [7:0]  wdata, rdata, rd_q, b[16];
    logic [6:0]  lens[3] = '{7'h00, 7'h01, 7'h02};
    logic [2:0]  port_mode;
    logic [31:0] exp_q[$];
    int          failures = 0, checked = 0;
    always #2.5 pclk = ~pclk;
    ppd_dma dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .peripheral_dma_ack_n(ack_n), .dma_wr_n(wr_n), .dma_rd_n(rd_n), .dma_tc(tc),
        .dma_wdata(wdata), .dma_req(dma_req), .dma_rdata(rdata), .service_intr(service_intr),
        .per_push(per_push), .per_push_data(per_push_data), .per_pop(per_pop), .per_rdata(per_rdata),
        .fifo_full(fifo_full), .fifo_empty(fifo_empty), .port_direction(port_direction),
        .port_mode(port_mode));
    ppd_host_model host (.pclk(pclk), .dma_rdata(rdata), .peripheral_dma_ack_n(ack_n),
        .dma_wr_n(wr_n), .dma_rd_n(rd_n), .dma_tc(tc), .dma_wdata(wdata), .rd_v(rd_v), .rd_q(rd_q));
    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        if (!wr) exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk(pslverr, a == 12'h010);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_req(input logic v);
        for (int i = 0; i < 20 && dma_req !== v; i++) @(posedge pclk);
        chk(dma_req, v);
    endtask
    task automatic dma_rd(input logic [7:0] e);
        exp_q.push_back(e);
        host.strobe(1'b0, 8'h00, 5 + $urandom % 4);
    endtask
    task automatic push(input logic [8:0] v);
        @(posedge pclk);
        per_push <= 1'b1;
        per_push_data <= v;
        @(posedge pclk);
        per_push <= 1'b0;
    endtask
    // one result at a time: oldest note matches
    always @(posedge pclk) begin
        if ((psel && penable && pready && !pwrite) || rd_v) chk(rd_v ? rd_q : prdata, exp_q.pop_front());
    end
    initial begin
        #100000;
        failures++;
        end_sim();
    end
    // ****
    // scenarios
    // ****
    initial begin
        void'($urandom(32'h8A20111B));
        {psel, penable, pwrite, per_push, per_pop, paddr, pwdata, per_push_data} <= '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `PPD_OFS_ECR, 8'h00, `PPD_ECR_RST);
        apb(1'b0, `PPD_OFS_CFGB, 8'h00, 8'h00);
        apb(1'b0, 12'h010, 8'h00, 8'h00);
        apb(1'b1, `PPD_OFS_ECR, 8'h48, 8'h00);
        wait_req(1'b1);
        host.ack(1'b0);
        for (int i = 0; i < 16; i++) begin
            b[i] = $urandom;
            host.strobe(1'b1, b[i], 5 + $urandom % 4);
        end
        wait_req(1'b0);
        chk(fifo_full, 1'b1);
        host.ack(1'b1);
        for (int i = 0; i < 16; i++) begin
            @(posedge pclk);
            per_pop <= 1'b1;
            @(posedge pclk);
            per_pop <= 1'b0;
            #1 chk(per_rdata, {1'b1, b[i]});
        end
        wait_req(1'b1);
        host.ack(1'b0);
        host.pulse_tc();
        for (int i = 0; i < 10 && service_intr !== 1'b1; i++) @(posedge pclk);
        chk(service_intr, 1'b1);
        wait_req(1'b0);
        apb(1'b0, `PPD_OFS_ECR, 8'h00, 8'h4D);
        repeat (60) @(posedge pclk);
        chk(dma_req, 1'b0);
        host.ack(1'b1);
        apb(1'b1, `PPD_OFS_ECR, 8'h48, 8'h00);
        wait_req(1'b1);
        apb(1'b1, `PPD_OFS_ECR, 8'h08, 8'h00);
        wait_req(1'b0);
        apb(1'b1, `PPD_OFS_ECR, 8'hC8, 8'h00);
        host.ack(1'b0);
        for (int i = 0; i < 17; i++) begin
            b[0] = $urandom;
            host.strobe(1'b1, b[0], 5);
            dma_rd(b[0]);
            if (i == 15) chk(dma_req, 1'b1);
        end
        wait_req(1'b0);
        host.ack(1'b1);
        wait_req(1'b1);
        apb(1'b1, `PPD_OFS_ECR, 8'h20, 8'h00);
        apb(1'b1, `PPD_OFS_CTRL, 8'h01, 8'h00);
        apb(1'b1, `PPD_OFS_ECR, 8'h68, 8'h00);
        host.ack(1'b0);
        foreach (lens[k]) begin
            b[0] = $urandom;
            push({2'b00, lens[k]});
            push({1'b1, b[0]});
            wait_req(1'b1);
            for (int j = 0; j <= lens[k]; j++) begin
                if (j % 2) apb(1'b0, k[0] ? `PPD_OFS_DATA : `PPD_OFS_FIFO, 8'h00, b[0]);
                else dma_rd(b[0]);
            end
            wait_req(1'b0);
        end
        host.ack(1'b1);
        chk({fifo_empty, port_direction, port_mode}, 5'h1B);
        end_sim();
    end
endmodule // parallel_port_fifo_dma_rle_test
